// ==== logic/lp4_timing_host.sv ====
// Host-side command spacing sequencer for one memory channel
`timescale 1ns/1ps
`default_nettype none
module lp4_timing_host #(
  parameter int RCD_PS   = 18000,
  parameter int RFCAB_PS = 280000
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire lp4_timing_pkg::req_t     req,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  wire logic                     bl32,
  input  wire logic                     long_vref,
  input  wire logic                     dqs_in,
  output lp4_timing_pkg::mem_pins_t     mem,
  output logic                          pre_timeout,
  output logic                          in_self_refresh,
  output logic                          in_training
);
  import lp4_timing_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT, S_PD, S_SRE_HOLD, S_SR_CLK, S_SR, S_SRX_CLK,
    S_CBT_STB, S_CBT_ENT, S_CBT, S_CBT_TOG, S_CBT_REL
  } state_t;

  // R01 R16 power-down exit plus row-to-column plus 3
  localparam int PD_CYC = XP_CYC + cyc(RCD_PS, 1) + 3;
  // R07 refresh cycle plus 7.5 ns
  localparam int XSR_CYC = cyc(RFCAB_PS + XSR_PS, XSR_MIN);

  state_t state_reg;
  state_t ret_reg;
  cnt_t   wait_reg;
  cnt_t   pd_reg;
  cnt_t   osc_reg;
  cnt_t   xsrw_reg;
  cnt_t   sdo_reg;
  logic   dqs_s1_reg;
  logic   dqs_s2_reg;
  logic   allow;
  logic   take;

  // R22 burst length 32 adds cycles
  function automatic cnt_t ld(input int c, input logic long_burst);
    int t;
    t = c - 1;
    if (long_burst)
      t = t + BL32_EXTRA;
    return cnt_t'(t);
  endfunction : ld

  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : mx

  // Strobe comes from the pin, so it is synchronised first
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dqs_s1_reg <= 1'b0;
      dqs_s2_reg <= 1'b0;
    end
    else
    begin
      dqs_s1_reg <= dqs_in;
      dqs_s2_reg <= dqs_s1_reg;
    end
  end

  always_comb
  begin
    allow = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        allow = !(req.kind inside {K_SRX, K_CBT_CMD, K_CBT_EXIT});
        // R01 R17 readout held off
        if (req.kind == K_MRR)
          allow = (pd_reg == '0) && (osc_reg == '0);
        // R16 FIFO write held off
        if (req.kind == K_MPC_WFIFO)
          allow = (pd_reg == '0);
        // R25 no restart before readout delay
        if (req.kind == K_OSC_START)
          allow = (osc_reg == '0);
        // R24 exit window admits mode and multipurpose only
        if (xsrw_reg != '0)
        begin
          if (!(req.kind inside {K_MRR, K_MRW, K_MPC_WFIFO, K_OSC_START, K_OSC_STOP}))
            allow = 1'b0;
          if (req.kind == K_MRW && req.pasr)
            allow = 1'b0;
        end
      end
      S_SR:
        allow = (req.kind == K_SRX);
      S_CBT:
        allow = (req.kind == K_CBT_CMD) || (req.kind == K_CBT_EXIT);
      default:
        allow = 1'b0;
    endcase
    take = req_valid && req_ready && allow;
  end

  // Sequencer, pins and ready
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      ret_reg   <= S_IDLE;
      wait_reg  <= '0;
      req_ready <= 1'b1;
      mem       <= '{cke: 1'b1, cs: 1'b0, ca: 6'h00, dqs_out: 1'b0,
                     dqs_oe: 1'b0, clk_run: 1'b1};
    end
    else
    begin
      mem.cs <= 1'b0;
      if (wait_reg != '0)
        wait_reg <= wait_reg - 10'h001;
      case (state_reg)
        S_IDLE:
        begin
          req_ready <= !take;
          if (take)
          begin
            mem.cs  <= (req.kind != K_PD);
            mem.ca  <= req.ca;
            state_reg <= S_WAIT;
            ret_reg <= S_IDLE;
            case (req.kind)
              // R02 read spacing
              K_MRR:       wait_reg <= ld(MRR_CYC, bl32);
              // R03 R04 write and set spacing
              K_MRW,
              K_PRE_TRAIN: wait_reg <= ld(mx(MRW_CYC, MRD_CYC), bl32);
              // R19 calibration reset
              K_ZQ_RESET:  wait_reg <= ld(ZQR_CYC, bl32);
              // R20 R21 set point switch
              K_FSP:       wait_reg <= ld(mx(FC_CYC, CKFSPE_CYC), bl32);
              K_PD:
              begin
                mem.cke   <= 1'b0;
                state_reg <= S_PD;
                wait_reg  <= ld(CKE_CYC + 1, 1'b0);
              end
              K_SRE:
              begin
                state_reg <= S_SRE_HOLD;
                wait_reg  <= ld(ESCKE_CYC + 1, 1'b0);
              end
              K_CBT_ENTER:
              begin
                // R10 strobe driven low ahead of clock enable
                mem.dqs_oe  <= 1'b1;
                mem.dqs_out <= 1'b0;
                state_reg   <= S_CBT_STB;
                wait_reg    <= ld(mx(DQSCKE_CYC, MRW_CYC), 1'b0);
              end
              default:     wait_reg <= ld(CMD_GAP_CYC, bl32);
            endcase
          end
        end
        // R26 blocked until the counter expires
        S_WAIT:
          if (wait_reg <= 10'h001)
          begin
            state_reg <= ret_reg;
            req_ready <= 1'b1;
          end
        S_PD:
          if (wait_reg <= 10'h001)
          begin
            mem.cke   <= 1'b1;
            state_reg <= S_WAIT;
            wait_reg  <= ld(XP_CYC, 1'b0);
          end
        // R05 clock enable held high
        S_SRE_HOLD:
          if (wait_reg <= 10'h001)
          begin
            mem.cke   <= 1'b0;
            state_reg <= S_SR_CLK;
            // R06 R08 minimum stay and clock hold
            wait_reg  <= ld(mx(CKELCK_CYC, SR_CYC) + 1, 1'b0);
          end
        S_SR_CLK:
          if (wait_reg <= 10'h001)
          begin
            // Clock may stop only after the hold, saving power in self refresh
            mem.clk_run <= 1'b0;
            state_reg   <= S_SR;
            req_ready   <= 1'b1;
          end
        S_SR:
        begin
          req_ready <= !take;
          if (take)
          begin
            mem.clk_run <= 1'b1;
            state_reg   <= S_SRX_CLK;
            wait_reg    <= ld(CKCKEH_CYC + 1, 1'b0);
          end
        end
        S_SRX_CLK:
          if (wait_reg <= 10'h001)
          begin
            mem.cke   <= 1'b1;
            state_reg <= S_WAIT;
            // R07 at least two cycles before the first command
            wait_reg  <= ld(XSR_MIN, 1'b0);
          end
        S_CBT_STB:
          if (wait_reg <= 10'h001)
          begin
            mem.cke   <= 1'b0;
            state_reg <= S_CBT_ENT;
            // R11 first training command delay
            wait_reg  <= ld(CAENT_CYC, 1'b0);
          end
        S_CBT_ENT:
          if (wait_reg <= 10'h001)
          begin
            state_reg <= S_CBT;
            req_ready <= 1'b1;
          end
        S_CBT:
        begin
          req_ready <= !take;
          if (take && req.kind == K_CBT_CMD)
          begin
            mem.cs    <= 1'b1;
            mem.ca    <= req.ca;
            state_reg <= S_CBT_TOG;
            // R12 select to strobe toggle
            wait_reg  <= ld(CS_DQS_CYC + 1, 1'b0);
          end
          else if (take)
          begin
            mem.cke   <= 1'b1;
            state_reg <= S_CBT_REL;
            // R13 strobe kept until released
            wait_reg  <= ld(CKEHDQS_CYC, 1'b0);
          end
        end
        S_CBT_TOG:
          if (wait_reg <= 10'h001)
          begin
            mem.dqs_out <= !mem.dqs_out;
            state_reg   <= S_WAIT;
            ret_reg     <= S_CBT;
            // R09 R15 spacing with clock running
            wait_reg    <= ld(mx(CACD_CYC, CKPSTCS_CYC), 1'b0);
          end
        S_CBT_REL:
          if (wait_reg <= 10'h001)
          begin
            mem.dqs_oe <= 1'b0;
            state_reg  <= S_WAIT;
            ret_reg    <= S_IDLE;
            // R14 training exit settle
            wait_reg   <= ld(long_vref ? XCBT_LONG_CYC : XCBT_CYC, 1'b0);
          end
        default:
        begin
          state_reg <= S_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  // R01 R16 power-down exit window
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pd_reg <= '0;
    else if (take && req.kind == K_PD)
      pd_reg <= cnt_t'(PD_CYC + CKE_CYC);
    else if (pd_reg != '0)
      pd_reg <= pd_reg - 10'h001;
  end

  // R17 R25 oscillator stop to readout
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      osc_reg <= '0;
    else if (take && req.kind == K_OSC_STOP)
      osc_reg <= cnt_t'(OSC_CYC);
    else if (osc_reg != '0)
      osc_reg <= osc_reg - 10'h001;
  end

  // R24 self refresh exit window, counted from the exit request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      xsrw_reg <= '0;
    else if (take && req.kind == K_SRX)
      xsrw_reg <= cnt_t'(XSR_CYC + CKCKEH_CYC);
    else if (xsrw_reg != '0)
      xsrw_reg <= xsrw_reg - 10'h001;
  end

  // R18 watch for the strobe after preamble training
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sdo_reg     <= '0;
      pre_timeout <= 1'b0;
    end
    else
    begin
      if (take && req.kind == K_PRE_TRAIN)
        sdo_reg <= cnt_t'(SDO_CYC + 2);
      else if (dqs_s2_reg)
        sdo_reg <= '0;
      else if (sdo_reg != '0)
        sdo_reg <= sdo_reg - 10'h001;
      // Expiry wins over a new request in the same cycle
      if (sdo_reg == 10'h001 && !dqs_s2_reg)
        pre_timeout <= 1'b1;
      else if (take && req.kind == K_PRE_TRAIN)
        pre_timeout <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      in_self_refresh <= 1'b0;
      in_training     <= 1'b0;
    end
    else
    begin
      in_self_refresh <= state_reg inside {S_SR_CLK, S_SR, S_SRX_CLK};
      in_training     <= state_reg inside {S_CBT_STB, S_CBT_ENT, S_CBT, S_CBT_TOG} ||
                         (state_reg == S_WAIT && ret_reg == S_CBT);
    end
  end
endmodule : lp4_timing_host
`default_nettype wire

// ==== pkg/lp4_timing_pkg.sv ====
// Timing constants, types and behaviour summary for the command spacing host
// Behaviour
// R01: After power-down exit plus its delay, wait row-to-column plus 3 cycles before MRR.
// R02: A mode read is followed by at least 8 cycles before the next command.
// R03: A mode write is followed by max(10 ns, 10 cycles) before the next command.
// R04: A mode set is followed by max(14 ns, 10 cycles) before dependent commands.
// R05: After self refresh entry keep clock enable high max(1.75 ns, 3 cycles).
// R06: Stay in self refresh at least max(15 ns, 3 cycles).
// R07: After self refresh exit wait refresh cycle plus 7.5 ns, at least 2 cycles.
// R08: After clock enable falls keep the clock running max(5 ns, 5 cycles).
// R09: Training commands are spaced by the 20 ns read delay rounded up.
// R10: Hold the strobe at a valid level 10 ns before clock enable falls.
// R11: First training command comes 250 ns after clock enable falls.
// R12: In training, toggle the strobe at least 2 cycles after select.
// R13: After clock enable rises, wait 10 ns before releasing the strobe.
// R14: After training exit wait 200 ns, or 250 ns for long steps, and 5 cycles.
// R15: After select in training keep the clock running max(7.5 ns, 5 cycles).
// R16: After power-down exit delay, wait row-to-column plus 3 cycles before FIFO write.
// R17: After oscillator stop wait max(40 ns, 8 cycles) before reading its count.
// R18: The device drives the strobe within max(20 ns, 12 cycles) of preamble training.
// R19: After impedance calibration reset wait max(50 ns, 3 cycles).
// R20: A set point switch takes 200 ns with no command meanwhile.
// R21: Keep clock running max(7.5 ns, 4 cycles) around a set point change.
// R22: With burst length 32 each command spacing grows by 8 cycles; power-down, self refresh and training waits do not.
// R23: A dual delay ends only when both time and cycle count have passed.
// R24: In the self refresh exit window only mode and multipurpose commands go.
// R25: No oscillator restart until the stop-to-readout delay has passed.
// R26: Each spacing is a cycle counter derived from time and clock period.
package lp4_timing_pkg;
  localparam int CK_PS = 20000;
  typedef logic [9:0] cnt_t;

  // R23 both bounds
  function automatic int cyc(input int ps, input int n);
    int c;
    c = (ps + CK_PS - 1) / CK_PS;
    if (c < 1)
      c = 1;
    return (c > n) ? c : n;
  endfunction : cyc

  localparam int MRR_CYC = 8;
  localparam int MRW_PS = 10000;
  localparam int MRD_PS = 14000;
  localparam int MRW_CYC = cyc(MRW_PS, 10);
  localparam int MRD_CYC = cyc(MRD_PS, 10);
  localparam int ESCKE_PS = 1750;
  localparam int ESCKE_CYC = cyc(ESCKE_PS, 3);
  localparam int SR_PS = 15000;
  localparam int SR_CYC = cyc(SR_PS, 3);
  localparam int XSR_PS = 7500;
  localparam int XSR_MIN = 2;
  localparam int CKELCK_PS = 5000;
  localparam int CKELCK_CYC = cyc(CKELCK_PS, 5);
  localparam int ADR_PS = 20000;
  localparam int CACD_CYC = cyc(ADR_PS, 1);
  localparam int DQSCKE_PS = 10000;
  localparam int DQSCKE_CYC = cyc(DQSCKE_PS, 1);
  localparam int CAENT_PS = 250000;
  localparam int CAENT_CYC = cyc(CAENT_PS, 1);
  localparam int CS_DQS_CYC = 2;
  localparam int CKEHDQS_PS = 10000;
  localparam int CKEHDQS_CYC = cyc(CKEHDQS_PS, 1);
  localparam int XCBT_PS = 200000;
  localparam int XCBT_LONG_PS = 250000;
  localparam int XCBT_CYC = cyc(XCBT_PS, 5);
  localparam int XCBT_LONG_CYC = cyc(XCBT_LONG_PS, 5);
  localparam int CKPSTCS_PS = 7500;
  localparam int CKPSTCS_CYC = cyc(CKPSTCS_PS, 5);
  localparam int OSC_PS = 40000;
  localparam int OSC_CYC = cyc(OSC_PS, 8);
  localparam int SDO_PS = 20000;
  localparam int SDO_CYC = cyc(SDO_PS, 12);
  localparam int ZQR_PS = 50000;
  localparam int ZQR_CYC = cyc(ZQR_PS, 3);
  localparam int FC_PS = 200000;
  localparam int FC_CYC = cyc(FC_PS, 1);
  localparam int CKFSPE_PS = 7500;
  localparam int CKFSPE_CYC = cyc(CKFSPE_PS, 4);
  localparam int CKE_PS = 7500;
  localparam int CKE_CYC = cyc(CKE_PS, 4);
  localparam int XP_PS = 7500;
  localparam int XP_CYC = cyc(XP_PS, 5);
  localparam int CKCKEH_PS = 1750;
  localparam int CKCKEH_CYC = cyc(CKCKEH_PS, 3);
  localparam int CMD_GAP_CYC = 2;
  localparam int BL32_EXTRA = 8;

  typedef enum logic [3:0] {
    K_MRR, K_MRW, K_PD, K_SRE, K_SRX, K_CBT_ENTER, K_CBT_CMD, K_CBT_EXIT,
    K_MPC_WFIFO, K_OSC_START, K_OSC_STOP, K_PRE_TRAIN, K_ZQ_RESET, K_FSP
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t  kind;
    logic       pasr;
    logic [5:0] ca;
  } req_t;

  typedef struct packed {
    logic       cke;
    logic       cs;
    logic [5:0] ca;
    logic       dqs_out;
    logic       dqs_oe;
    logic       clk_run;
  } mem_pins_t;
endpackage : lp4_timing_pkg

// ==== verif/lp4_timing_host_props.sv ====
// Concurrent checks on the command spacing host ports
`timescale 1ns/1ps
`default_nettype none
module lp4_timing_host_props #(
  parameter int RCD_PS   = 18000,
  parameter int RFCAB_PS = 280000
) (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire lp4_timing_pkg::req_t      req,
  input wire logic                      req_valid,
  input wire logic                      req_ready,
  input wire logic                      bl32,
  input wire logic                      long_vref,
  input wire logic                      dqs_in,
  input wire lp4_timing_pkg::mem_pins_t mem,
  input wire logic                      pre_timeout,
  input wire logic                      in_self_refresh,
  input wire logic                      in_training
);
  import lp4_timing_pkg::*;
  logic [4:0] low_cnt;
  // Saturates so a long low phase cannot wrap into a false failure
  always_ff @(posedge sys_clk)
  begin
    if (rst || mem.cke)
      low_cnt <= 5'h00;
    else if (low_cnt != 5'h1F)
      low_cnt <= low_cnt + 5'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  mrr_gap_a: assert property (mem.cs && $past(req.kind) == K_MRR |=> !mem.cs [*7])
    else $error("mode read spacing short");
  mrw_gap_a: assert property (mem.cs && $past(req.kind) == K_MRW |=> !mem.cs [*8])
    else $error("mode write spacing short");
  zq_gap_a: assert property (mem.cs && $past(req.kind) == K_ZQ_RESET |=> !mem.cs [*2])
    else $error("calibration reset spacing short");
  fsp_gap_a: assert property (mem.cs && $past(req.kind) == K_FSP |=> !mem.cs [*8])
    else $error("set point switch spacing short");
  sre_hold_a: assert property (mem.cs && $past(req.kind) == K_SRE |-> mem.cke [*3])
    else $error("clock enable fell too early");
  sr_stay_a: assert property ($fell(mem.cke) |-> !mem.cke [*3])
    else $error("low phase too short");
  clk_hold_a: assert property ($fell(mem.cke) |-> mem.clk_run [*5])
    else $error("clock stopped too soon");
  strobe_low_a: assert property ($fell(mem.cke) && mem.dqs_oe |->
    $past(mem.dqs_oe) && !$past(mem.dqs_out))
    else $error("strobe not held low");
  cbt_first_a: assert property (mem.cs && !mem.cke |-> low_cnt >= 5'h0D)
    else $error("training command too early");
  cbt_strobe_a: assert property (mem.cs && !mem.cke |=> $stable(mem.dqs_out))
    else $error("strobe toggled too soon");
  clk_cs_a: assert property (mem.cs && !mem.cke |-> mem.clk_run [*5])
    else $error("clock stopped after select");
  strobe_keep_a: assert property ($rose(mem.cke) && $past(mem.dqs_oe) |-> mem.dqs_oe)
    else $error("strobe released too soon");
  cbt_exit_a: assert property ($rose(mem.cke) && mem.dqs_oe |=> !mem.cs [*8])
    else $error("command too soon after training");
  c_mrr: cover property (mem.cs && $past(req.kind) == K_MRR);
  c_sr: cover property ($fell(mem.clk_run));
  c_pre: cover property ($rose(pre_timeout));
endmodule : lp4_timing_host_props
bind lp4_timing_host lp4_timing_host_props #(.RCD_PS(RCD_PS), .RFCAB_PS(RFCAB_PS)) u_props (
  .sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
  .bl32(bl32), .long_vref(long_vref), .dqs_in(dqs_in), .mem(mem),
  .pre_timeout(pre_timeout), .in_self_refresh(in_self_refresh), .in_training(in_training));
`default_nettype wire

// ==== verif/lp4_dev_model.sv ====
// Behavioural memory channel answering read preamble training
`timescale 1ns/1ps
`default_nettype none
module lp4_dev_model (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire lp4_timing_pkg::mem_pins_t mem,
  input  wire logic                      arm,
  input  wire logic [3:0]                lat,
  output logic                           dqs_in
);
  import lp4_timing_pkg::*;
  logic [4:0] ph_reg;
  logic       tog_reg;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ph_reg  <= 5'h00;
      tog_reg <= 1'b0;
    end
    else
    begin
      tog_reg <= ~tog_reg;
      if (mem.cs && arm && mem.cke)
        ph_reg <= {1'b0, lat} + 5'h08;
      else if (ph_reg != 5'h00)
        ph_reg <= ph_reg - 5'h01;
    end
  end
  // Released strobe sits low on the termination; host drive wins
  assign dqs_in = mem.dqs_oe ? mem.dqs_out : (ph_reg != 5'h00 && ph_reg < 5'h09) & tog_reg;
endmodule : lp4_dev_model
`default_nettype wire

// ==== verif/lp4_timing_host_tb.sv ====
// Self-checking bench for the command spacing host
`timescale 1ns/1ps
`default_nettype none
module lp4_timing_host_tb;
  import lp4_timing_pkg::*;
  typedef struct { cmd_kind_t k; int n; } row_t;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  req_t       req = '0;
  logic       req_valid = 1'b0;
  logic       bl32 = 1'b0;
  logic       long_vref = 1'b0;
  logic       arm = 1'b1;
  logic [3:0] lat = 4'h8;
  logic       req_ready;
  logic       dqs_in;
  logic       pre_timeout;
  logic       in_self_refresh;
  logic       in_training;
  mem_pins_t  mem;
  mem_pins_t  snap;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc_no = 0;
  int         k;
  int         t0;
  int         t_cs;
  row_t       rows [8] = '{'{K_MRR, 8}, '{K_MRW, 10}, '{K_ZQ_RESET, 3}, '{K_FSP, 10},
    '{K_MPC_WFIFO, 2}, '{K_OSC_START, 2}, '{K_PRE_TRAIN, 10}, '{K_OSC_STOP, 2}};
  cmd_kind_t  pdk [2] = '{K_MRR, K_MPC_WFIFO};
  cmd_kind_t  osk [2] = '{K_MRR, K_OSC_START};

  lp4_timing_host uut (.sys_clk(sys_clk), .rst(rst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .bl32(bl32), .long_vref(long_vref), .dqs_in(dqs_in), .mem(mem),
    .pre_timeout(pre_timeout), .in_self_refresh(in_self_refresh), .in_training(in_training));
  lp4_dev_model u_dev (.sys_clk(sys_clk), .rst(rst), .mem(mem), .arm(arm), .lat(lat),
    .dqs_in(dqs_in));

  always #10 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready();
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end while (!req_ready && k < 400);
  endtask : wait_ready

  task automatic wait_pin(input logic use_clk, input logic lvl);
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end while ((use_clk ? mem.clk_run : mem.cke) !== lvl && k < 400);
  endtask : wait_pin

  // Request held until the cycle after it is taken, then dropped on an edge
  task automatic issue(input cmd_kind_t kd, input logic p);
    wait_ready();
    @(posedge sys_clk);
    req       <= '{kd, p, 6'(kd) ^ 6'h2A};
    req_valid <= 1'b1;
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end while (req_ready && k < 400);
    snap = mem;
    t_cs = cyc_no;
    @(posedge sys_clk);
    req_valid <= 1'b0;
  endtask : issue

  always @(posedge sys_clk)
  begin
    cyc_no <= cyc_no + 1;
    if (cyc_no == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({mem, req_ready, pre_timeout}, {11'h401, 2'h2});
    $display("test reset done");
    for (int v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      bl32 <= v[0];
      foreach (rows[i])
      begin
        issue(rows[i].k, 1'b0);
        check({snap.cs, snap.ca}, {1'b1, 6'(rows[i].k) ^ 6'h2A});
        wait_ready();
        check(k, rows[i].n - 1 + 8 * v);
      end
    end
    $display("test spacing rows done");
    // Short spacing, so only the windows can hold the next command back
    @(posedge sys_clk);
    bl32 <= 1'b0;
    foreach (osk[i])
    begin
      issue(K_OSC_STOP, 1'b0);
      t0 = t_cs;
      issue(osk[i], 1'b0);
      check(t_cs - t0 >= 8, 1'b1);
    end
    foreach (pdk[i])
    begin
      issue(K_PD, 1'b0);
      wait_pin(1'b0, 1'b1);
      t0 = cyc_no;
      issue(pdk[i], 1'b0);
      check(t_cs - t0 >= 9, 1'b1);
    end
    $display("test windows done");
    issue(K_SRE, 1'b0);
    t0 = t_cs;
    wait_pin(1'b0, 1'b0);
    check(cyc_no - t0 >= 3, 1'b1);
    t0 = cyc_no;
    wait_pin(1'b1, 1'b0);
    check(cyc_no - t0 >= 5, 1'b1);
    check(in_self_refresh, 1'b1);
    issue(K_SRX, 1'b0);
    t0 = t_cs;
    issue(K_MRW, 1'b1);
    check(t_cs - t0 >= 15, 1'b1);
    check(in_self_refresh, 1'b0);
    $display("test self refresh done");
    for (int v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      long_vref <= v[0];
      issue(K_CBT_ENTER, 1'b0);
      check({snap.dqs_oe, snap.dqs_out}, 2'b10);
      wait_pin(1'b0, 1'b0);
      t0 = cyc_no;
      issue(K_CBT_CMD, 1'b0);
      check(t_cs - t0 >= 13, 1'b1);
      repeat (3) @(negedge sys_clk);
      check(in_training, 1'b1);
      issue(K_CBT_EXIT, 1'b0);
      check({snap.cke, snap.dqs_oe}, 2'b11);
      wait_ready();
      check(k >= (v ? 12 : 9), 1'b1);
      check(in_training, 1'b0);
    end
    $display("test training done");
    for (int v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      arm <= v[0];
      issue(K_PRE_TRAIN, 1'b0);
      repeat (20) @(negedge sys_clk);
      check(pre_timeout, !v[0]);
    end
    $display("test preamble done");
    // Reset while clock enable is low must bring every pin back to idle
    issue(K_PD, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check({mem, req_ready, pre_timeout}, {11'h401, 2'h2});
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : lp4_timing_host_tb
`default_nettype wire
